// *** dv/cmp_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module cmp_model (
  // clock
  input wire logic pclk,
  // levels the bench asks for: [0] comparator 1, [1] comparator 2
  input wire logic [1:0] level,
  // comparator outputs
  output logic cmp1_output,
  output logic cmp2_output
);
  // ------------------------------
  // comparator levels
  // ------------------------------
  // outputs take the requested level on the next pclk rising edge, in step with the bus clock
  initial begin
    cmp1_output = 1'b0;
    cmp2_output = 1'b0;
  end
  always @(posedge pclk) begin
    cmp1_output <= level[0];
    cmp2_output <= level[1];
  end
endmodule
`default_nettype wire

// *** dv/testbench.sv ***
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin n_fail++; \
  $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module testbench;
  typedef struct packed {logic [7:0] ctrl; logic [1:0] lvl; logic q;} row_t;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hf;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err, pin1_out, pin1_oe, pin2_out, pin2_oe;
  logic cmp1_output, cmp2_output;
  logic [1:0] level = 2'b00;
  row_t r;
  int n_fail = 0;
  int num_checks = 0;
  int cyc = 0;
  int t0;
  row_t rows [8] = '{'{8'h00, 2'b01, 1'b0}, '{8'hc0, 2'b00, 1'b0}, '{8'he0, 2'b01, 1'b1},
    '{8'h40, 2'b10, 1'b1}, '{8'hd0, 2'b10, 1'b0}, '{8'hf0, 2'b11, 1'b0},
    '{8'h88, 2'b00, 1'b1}, '{8'hc4, 2'b00, 1'b0}};

  always #2 pclk = ~pclk;
  always @(posedge pclk) cyc <= cyc + 1;

  cmp_model u_cmp (.pclk(pclk), .level(level), .cmp1_output(cmp1_output),
    .cmp2_output(cmp2_output));
  sr_latch_out dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cmp1_output(cmp1_output),
    .cmp2_output(cmp2_output), .pin1_out(pin1_out), .pin1_oe(pin1_oe),
    .pin2_out(pin2_out), .pin2_oe(pin2_oe));

  // ------------------------------
  // bus and helper tasks
  // ------------------------------
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    err = pslverr;
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    // one idle cycle between transfers
    @(posedge pclk);
  endtask

  task automatic wait_rise();
    int n;
    n = 0;
    while (pin1_out !== 1'b0 && n < 400) begin @(posedge pclk); n++; end
    while (pin1_out !== 1'b1 && n < 400) begin @(posedge pclk); n++; end
    if (n >= 400) n_fail++;
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge pclk);
    n_fail++;
    results();
  end

  // ------------------------------
  // main sequence
  // ------------------------------
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, sr_latch_pkg::ctrl0_addr, 32'h0);
    `CHK("ctrl0 reset", 32'h0, rd)
    apb(1'b0, sr_latch_pkg::prescale_addr, 32'h0);
    `CHK("prescale reset", 32'h0, rd)
    `CHK("pin1 oe reset", 1'b0, pin1_oe)
    apb(1'b1, sr_latch_pkg::ctrl0_addr, 32'h0e);
    apb(1'b0, sr_latch_pkg::ctrl0_addr, 32'h0);
    `CHK("pulse bits read", 32'h0, rd)
    apb(1'b1, sr_latch_pkg::pin_cfg_addr, 32'h0c);
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      r = rows[i];
      level <= r.lvl;
      repeat (4) @(posedge pclk);
      apb(1'b1, sr_latch_pkg::ctrl0_addr, {24'h0, r.ctrl});
      repeat (6) @(posedge pclk);
      `CHK("pin1", r.ctrl[6] ? r.q : r.lvl[0], pin1_out)
      `CHK("pin2", r.ctrl[7] ? ~r.q : r.lvl[1], pin2_out)
      apb(1'b0, sr_latch_pkg::status_addr, 32'h0);
      `CHK("status", {29'h0, r.q, r.lvl}, rd)
      apb(1'b0, sr_latch_pkg::ctrl0_addr, 32'h0);
      `CHK("ctrl0", {24'h0, r.ctrl & 8'hf1}, rd)
      $display("test row %0d done", i);
    end
    apb(1'b1, sr_latch_pkg::pin_cfg_addr, 32'h06);
    repeat (3) @(posedge pclk);
    `CHK("pin1 oe", 1'b1, pin1_oe)
    `CHK("pin2 oe", 1'b0, pin2_oe)
    apb(1'b1, sr_latch_pkg::pin_cfg_addr, 32'h0c);
    apb(1'b1, 12'h010, 32'hff);
    `CHK("unmapped write err", 1'b1, err)
    apb(1'b0, 12'h010, 32'h0);
    `CHK("unmapped read", 32'h0, rd)
    apb(1'b1, sr_latch_pkg::prescale_addr, 32'hffffffff);
    apb(1'b0, sr_latch_pkg::prescale_addr, 32'h0);
    `CHK("prescale read", 32'hc0, rd)
    pstrb <= 4'h0;
    apb(1'b1, sr_latch_pkg::prescale_addr, 32'h0);
    pstrb <= 4'hf;
    apb(1'b0, sr_latch_pkg::prescale_addr, 32'h0);
    `CHK("strobe off write", 32'hc0, rd)
    $display("test map done");
    for (int s = 0; s < 4; s++) begin
      apb(1'b1, sr_latch_pkg::prescale_addr, {24'h0, s[1:0], 6'h0});
      apb(1'b1, sr_latch_pkg::ctrl0_addr, 32'h45);
      wait_rise();
      t0 = cyc;
      apb(1'b1, sr_latch_pkg::ctrl0_addr, 32'h45);
      wait_rise();
      `CHK("set clock period", 16 << s, cyc - t0)
    end
    apb(1'b1, sr_latch_pkg::ctrl0_addr, 32'h44);
    repeat (300) @(posedge pclk);
    `CHK("clock off", 1'b0, pin1_out)
    $display("test set clock done");
    level <= 2'b01;
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b1, sr_latch_pkg::pin_cfg_addr, 32'h0c);
    repeat (6) @(posedge pclk);
    `CHK("pin1 after reset", 1'b1, pin1_out)
    `CHK("pin2 after reset", 1'b0, pin2_out)
    apb(1'b0, sr_latch_pkg::status_addr, 32'h0);
    `CHK("latch after reset", 32'h1, rd)
    $display("test second reset done");
    results();
  end
endmodule
`default_nettype wire

// *** rtl/set_clock_div.sv ***
`timescale 1ns/1ns
`default_nettype none
module set_clock_div #(
  parameter int width = sr_latch_pkg::div_width
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // rate select: period is 16 << sel
  input wire logic [1:0] sel,
  output logic tick
);
  logic [width-1:0] count;
  logic [width-1:0] last;

  always_comb begin
    last = ({{(width-4){1'b0}}, 4'hf} << sel) | {{(width-4){1'b0}}, 4'hf};
  end

  // free-running divider, one pulse per period
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= '0;
    end else if (count >= last) begin
      count <= '0;
    end else begin
      count <= count + 1'b1;
    end
  end

  assign tick = (count == last);

  a_tick_period: assert property (@(posedge pclk) disable iff (!presetn)
    tick && $stable(sel) ##1 $stable(sel) |-> !tick ##14 !tick)
    else $error("set clock pulses too close");
endmodule
`default_nettype wire

// *** rtl/sr_latch_out.sv ***
`timescale 1ns/1ns
`default_nettype none
module sr_latch_out (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // comparator outputs
  input wire logic cmp1_output,
  input wire logic cmp2_output,
  // pins
  output logic pin1_out,
  output logic pin1_oe,
  output logic pin2_out,
  output logic pin2_oe
);

  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  logic [7:0] latch_control_0;
  logic [1:0] set_clock_divider_select;
  logic [3:0] pin_cfg;
  logic cmp1_s;
  logic cmp2_s;
  logic q;
  logic latch_set_clock;
  logic soft_set;
  logic soft_reset;
  logic set_in;
  logic reset_in;
  logic wr;
  logic rd;
  logic mapped;
  logic wr_ctrl0;
  logic wr_prescale;
  logic wr_pin_cfg;
  logic [31:0] next_prdata;
  logic [7:0] tick_gap;
  logic gap_valid;

  sync2 u_sync1 (
    .pclk(pclk),
    .presetn(presetn),
    .din(cmp1_output),
    .dout(cmp1_s)
  );

  sync2 u_sync2 (
    .pclk(pclk),
    .presetn(presetn),
    .din(cmp2_output),
    .dout(cmp2_s)
  );

  set_clock_div u_div (
    .pclk(pclk),
    .presetn(presetn),
    .sel(set_clock_divider_select),
    .tick(latch_set_clock)
  );

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  assign pready = 1'b1;
  assign wr = psel && penable && pwrite && pstrb[0];
  // read data is fetched in the setup cycle so it stands at the access edge
  assign rd = psel && !penable && !pwrite;
  assign wr_ctrl0 = wr && (paddr == sr_latch_pkg::ctrl0_addr);
  assign wr_prescale = wr && (paddr == sr_latch_pkg::prescale_addr);
  assign wr_pin_cfg = wr && (paddr == sr_latch_pkg::pin_cfg_addr);
  assign mapped = (paddr == sr_latch_pkg::ctrl0_addr) ||
                  (paddr == sr_latch_pkg::prescale_addr) ||
                  (paddr == sr_latch_pkg::pin_cfg_addr) ||
                  (paddr == sr_latch_pkg::status_addr);
  assign pslverr = psel && penable && !mapped;

  // pulse bits are never stored, so they read as zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      latch_control_0 <= sr_latch_pkg::ctrl0_reset;
    end else if (wr_ctrl0) begin
      latch_control_0 <= pwdata[7:0] & sr_latch_pkg::ctrl0_store_mask;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      soft_set <= 1'b0;
      soft_reset <= 1'b0;
    end else begin
      soft_set <= wr && paddr == sr_latch_pkg::ctrl0_addr &&
                  pwdata[sr_latch_pkg::soft_set_bit];
      soft_reset <= wr && paddr == sr_latch_pkg::ctrl0_addr &&
                    pwdata[sr_latch_pkg::soft_reset_bit];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      set_clock_divider_select <= sr_latch_pkg::prescale_reset;
    end else if (wr_prescale) begin
      set_clock_divider_select <= pwdata[sr_latch_pkg::div_sel_lsb +: 2];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_cfg <= sr_latch_pkg::pin_cfg_reset;
    end else if (wr_pin_cfg) begin
      pin_cfg <= pwdata[3:0];
    end
  end

  always_comb begin
    case (paddr)
      sr_latch_pkg::ctrl0_addr: next_prdata = {24'h000000, latch_control_0};
      sr_latch_pkg::prescale_addr:
        next_prdata = {24'h000000, set_clock_divider_select, 6'h00};
      sr_latch_pkg::pin_cfg_addr: next_prdata = {28'h0000000, pin_cfg};
      sr_latch_pkg::status_addr: next_prdata = {29'h0, q, cmp2_s, cmp1_s};
      default: next_prdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd) begin
      prdata <= next_prdata;
    end
  end

  // ----------------------------------------------------------------
  // latch
  // ----------------------------------------------------------------
  assign set_in = (latch_control_0[sr_latch_pkg::cmp1_set_en_bit] && cmp1_s) ||
                  soft_set ||
                  (latch_control_0[sr_latch_pkg::set_clk_en_bit] && latch_set_clock);
  assign reset_in = (latch_control_0[sr_latch_pkg::cmp2_reset_en_bit] && cmp2_s) ||
                    soft_reset;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= 1'b0;
    end else if (reset_in) begin
      q <= 1'b0;
    end else if (set_in) begin
      q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // output multiplexers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin1_out <= 1'b0;
      pin2_out <= 1'b0;
      pin1_oe <= 1'b0;
      pin2_oe <= 1'b0;
    end else begin
      pin1_out <= latch_control_0[sr_latch_pkg::pin1_sel_bit] ? q : cmp1_s;
      pin2_out <= latch_control_0[sr_latch_pkg::pin2_sel_bit] ? !q : cmp2_s;
      pin1_oe <= !pin_cfg[sr_latch_pkg::dir1_bit] && pin_cfg[sr_latch_pkg::oe1_bit];
      pin2_oe <= !pin_cfg[sr_latch_pkg::dir2_bit] && pin_cfg[sr_latch_pkg::oe2_bit];
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_pin2_mux: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 pin2_out == ($past(latch_control_0[7]) ? !$past(q) : $past(cmp2_s)))
    else $error("pin 2 mux wrong");

  a_pin1_mux: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 pin1_out == ($past(latch_control_0[6]) ? $past(q) : $past(cmp1_s)))
    else $error("pin 1 mux wrong");

  a_reset_dominant: assert property (@(posedge pclk) disable iff (!presetn)
    reset_in && set_in |=> !q)
    else $error("latch not reset dominant");

  a_cmp1_set: assert property (@(posedge pclk) disable iff (!presetn)
    latch_control_0[5] && cmp1_s && !reset_in |=> q)
    else $error("comparator 1 did not set latch");

  a_cmp2_reset: assert property (@(posedge pclk) disable iff (!presetn)
    latch_control_0[4] && cmp2_s |=> !q)
    else $error("comparator 2 did not reset latch");

  a_soft_set: assert property (@(posedge pclk) disable iff (!presetn)
    wr && paddr == 12'h000 && pwdata[3] |=> soft_set ##1 (!soft_set || $past(wr)))
    else $error("soft set pulse wrong");

  a_soft_clear_bits: assert property (@(posedge pclk) disable iff (!presetn)
    latch_control_0[3:1] == 3'h0)
    else $error("pulse bits not self clearing");

  a_latch_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !set_in && !reset_in |=> q == $past(q))
    else $error("latch did not hold");

  a_pin_enable: assert property (@(posedge pclk) disable iff (!presetn)
    pin_cfg[0] |=> !pin1_oe)
    else $error("pin 1 driven while input");

  a_clock_gate: assert property (@(posedge pclk) disable iff (!presetn)
    !latch_control_0[0] && !soft_set && !(latch_control_0[5] && cmp1_s) |-> !set_in)
    else $error("set clock leaked to latch");

  // ----------------------------------------------------------------
  // set clock period watch
  // ----------------------------------------------------------------
  // a rate change drops gap_valid, so only whole periods are compared
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_gap <= 8'h00;
      gap_valid <= 1'b0;
    end else if (wr_prescale) begin
      tick_gap <= 8'h00;
      gap_valid <= 1'b0;
    end else if (latch_set_clock) begin
      tick_gap <= 8'h01;
      gap_valid <= 1'b1;
    end else if (tick_gap != 8'hff) begin
      tick_gap <= tick_gap + 8'h01;
    end
  end

  a_tick_gap: assert property (@(posedge pclk) disable iff (!presetn)
    latch_set_clock && gap_valid |-> tick_gap == (8'h10 << set_clock_divider_select))
    else $error("set clock period wrong");

  a_tick_single: assert property (@(posedge pclk) disable iff (!presetn)
    latch_set_clock |=> !latch_set_clock)
    else $error("set clock pulse too long");

  a_sel_write: assert property (@(posedge pclk) disable iff (!presetn)
    wr_prescale |=> set_clock_divider_select == $past(pwdata[7:6]))
    else $error("prescale select not stored");

  a_pin2_dir_off: assert property (@(posedge pclk) disable iff (!presetn)
    pin_cfg[sr_latch_pkg::dir2_bit] |=> !pin2_oe)
    else $error("pin 2 driven while input");

  a_pin1_oe_on: assert property (@(posedge pclk) disable iff (!presetn)
    !pin_cfg[sr_latch_pkg::dir1_bit] && pin_cfg[sr_latch_pkg::oe1_bit] |=> pin1_oe)
    else $error("pin 1 not driven");

  a_pin2_oe_on: assert property (@(posedge pclk) disable iff (!presetn)
    !pin_cfg[sr_latch_pkg::dir2_bit] && pin_cfg[sr_latch_pkg::oe2_bit] |=> pin2_oe)
    else $error("pin 2 not driven");

  a_pin1_oe_gate: assert property (@(posedge pclk) disable iff (!presetn)
    !pin_cfg[sr_latch_pkg::oe1_bit] |=> !pin1_oe)
    else $error("pin 1 driven without enable");

  a_pin2_oe_gate: assert property (@(posedge pclk) disable iff (!presetn)
    !pin_cfg[sr_latch_pkg::oe2_bit] |=> !pin2_oe)
    else $error("pin 2 driven without enable");

  a_soft_reset: assert property (@(posedge pclk) disable iff (!presetn)
    wr_ctrl0 && pwdata[sr_latch_pkg::soft_reset_bit] |=> soft_reset ##1 !q)
    else $error("soft reset pulse wrong");

  a_soft_set_q: assert property (@(posedge pclk) disable iff (!presetn)
    soft_set && !reset_in |=> q)
    else $error("soft set did not set latch");

  a_set_pulse_once: assert property (@(posedge pclk) disable iff (!presetn)
    !(wr_ctrl0 && pwdata[sr_latch_pkg::soft_set_bit]) |=> !soft_set)
    else $error("soft set pulse without write");

  a_reset_pulse_once: assert property (@(posedge pclk) disable iff (!presetn)
    !(wr_ctrl0 && pwdata[sr_latch_pkg::soft_reset_bit]) |=> !soft_reset)
    else $error("soft reset pulse without write");

  a_clock_sets: assert property (@(posedge pclk) disable iff (!presetn)
    latch_control_0[sr_latch_pkg::set_clk_en_bit] && latch_set_clock && !reset_in |=> q)
    else $error("set clock did not set latch");

  a_cmp1_ignored: assert property (@(posedge pclk) disable iff (!presetn)
    !latch_control_0[5] && !soft_set && !(latch_control_0[0] && latch_set_clock) && !q
    |=> !q)
    else $error("comparator 1 set latch while disabled");

  a_cmp2_ignored: assert property (@(posedge pclk) disable iff (!presetn)
    !latch_control_0[4] && !soft_reset && q |=> q)
    else $error("comparator 2 reset latch while disabled");

  a_mux_reset_default: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(presetn) |-> !latch_control_0[7] && !latch_control_0[6])
    else $error("output mux not default after reset");

  a_status_read: assert property (@(posedge pclk) disable iff (!presetn)
    rd && paddr == sr_latch_pkg::status_addr
    |=> prdata == {29'h0, $past(q), $past(cmp2_s), $past(cmp1_s)})
    else $error("status read wrong");

  a_unmapped_zero: assert property (@(posedge pclk) disable iff (!presetn)
    rd && !mapped |=> prdata == 32'h0000_0000)
    else $error("unmapped read not zero");

  a_prescale_read: assert property (@(posedge pclk) disable iff (!presetn)
    rd && paddr == sr_latch_pkg::prescale_addr
    |=> prdata[5:0] == 6'h00 && prdata[31:8] == 24'h000000)
    else $error("prescale spare bits not zero");

  a_ctrl_read_bits: assert property (@(posedge pclk) disable iff (!presetn)
    rd && paddr == sr_latch_pkg::ctrl0_addr
    |=> prdata[3:1] == 3'h0 && prdata[31:8] == 24'h000000)
    else $error("control spare bits not zero");

  a_q_fall_cause: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(q) |-> $past(reset_in))
    else $error("latch cleared without reset");

  a_q_rise_cause: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(q) |-> $past(set_in) && !$past(reset_in))
    else $error("latch set without set");

endmodule
`default_nettype wire

// *** rtl/sr_latch_pkg.sv ***
package sr_latch_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [11:0] ctrl0_addr = 12'h000;
  localparam logic [11:0] prescale_addr = 12'h004;
  localparam logic [11:0] pin_cfg_addr = 12'h008;
  localparam logic [11:0] status_addr = 12'h00c;

  localparam logic [7:0] ctrl0_reset = 8'h00;
  localparam logic [1:0] prescale_reset = 2'h0;
  localparam logic [3:0] pin_cfg_reset = 4'h0;

  // ----------------------------------------------------------------
  // latch_control_0 fields
  // ----------------------------------------------------------------
  localparam int pin2_sel_bit = 7;
  localparam int pin1_sel_bit = 6;
  localparam int cmp1_set_en_bit = 5;
  localparam int cmp2_reset_en_bit = 4;
  localparam int soft_set_bit = 3;
  localparam int soft_reset_bit = 2;
  localparam int set_clk_en_bit = 0;
  localparam logic [7:0] ctrl0_store_mask = 8'hf1;

  // ----------------------------------------------------------------
  // latch_clock_prescale and own registers
  // ----------------------------------------------------------------
  localparam int div_sel_lsb = 6;
  // pin config: [0] dir1 [1] dir2 [2] oe1 [3] oe2
  localparam int dir1_bit = 0;
  localparam int dir2_bit = 1;
  localparam int oe1_bit = 2;
  localparam int oe2_bit = 3;
  // status: [0] cmp1 [1] cmp2 [2] q
  localparam int div_width = 7;
  localparam int sync_stages = 2;

endpackage

// *** rtl/sync2.sv ***
`timescale 1ns/1ns
`default_nettype none
module sync2 (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // data
  input wire logic din,
  output logic dout
);
  logic first;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      first <= 1'b0;
      dout <= 1'b0;
    end else begin
      first <= din;
      dout <= first;
    end
  end
endmodule
`default_nettype wire
